// >>> rtl/hprw_params.svh
`ifndef HPRW_PARAMS_SVH
`define HPRW_PARAMS_SVH

// command and reply packet types
`define HPRW_CMD_PWR_CFG 8'h1C
`define HPRW_CMD_WDOG 8'h1D
`define HPRW_RSP_OR 8'h40
`define HPRW_LEN_ONE 8'h01
`define HPRW_LEN_TWO 8'h02

// function mask bit positions
`define HPRW_BIT_AUTO_POL 0
`define HPRW_BIT_RST_INV 1
`define HPRW_BIT_PWR_INV 2
`define HPRW_BIT_BLANK 4
`define HPRW_BIT_REBOOT 5
`define HPRW_BIT_WAKE 6
`define HPRW_BIT_SHUTDOWN 7

// reset values
`define HPRW_MASK_RST 8'h00
`define HPRW_PLEN_RST 8'h20
`define HPRW_WDOG_RST 8'h00

// pulse length that means hold until sense changes
`define HPRW_PLEN_HOLD 8'hFF

// key and pulse timing, in 1/32 s ticks
`define HPRW_HOLD_LONG_TICKS 8'h80
`define HPRW_HOLD_SHORT_TICKS 8'h08
`define HPRW_RST_PULSE_TICKS 8'h20
`define HPRW_EXTEND_TICKS 8'hA0
`define HPRW_TICKS_PER_SEC 5'h1F

// clock and tick timing
`define HPRW_CLK_FREQ_HZ 50000000
`define HPRW_TICK_RATE_HZ 32
`define HPRW_TICK_CYC (`HPRW_CLK_FREQ_HZ / `HPRW_TICK_RATE_HZ)

`endif

// >>> rtl/hprw_pkg.sv
package hprw_pkg;

    typedef enum logic [2:0]
    {
        HPRW_IDLE = 3'h0,
        HPRW_RST_PULSE = 3'h1,
        HPRW_PWR_PULSE = 3'h2,
        HPRW_PWR_EXTEND = 3'h3,
        HPRW_SELF_RST = 3'h4
    } hprw_state_e;

endpackage

// >>> rtl/hprw_tick_gen.sv
`timescale 1ns/100ps
`include "hprw_params.svh"

module hprw_tick_gen
#(
    parameter int TICK_CYC = `HPRW_TICK_CYC
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clr_in,
    output logic tick32_out,
    output logic tick_sec_out
);

    localparam int W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

    logic [W-1:0] div_r;
    logic [W-1:0] div_nxt;
    logic [4:0] sec_r;
    logic [4:0] sec_nxt;
    logic t32_r;
    logic t32_nxt;
    logic ts_r;
    logic ts_nxt;

    // 1/32 s tick from the clock, 1 s tick from 32 of those
    always_comb
    begin
        div_nxt = div_r + W'(1);
        sec_nxt = sec_r;
        t32_nxt = 1'b0;
        ts_nxt = 1'b0;
        if (clr_in)
        begin
            div_nxt = '0;
            sec_nxt = 5'h00;
        end
        else if (div_r == W'(TICK_CYC - 1))
        begin
            div_nxt = '0;
            t32_nxt = 1'b1;
            sec_nxt = sec_r + 5'h01;
            if (sec_r == `HPRW_TICKS_PER_SEC)
            begin
                ts_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_r <= '0;
            sec_r <= 5'h00;
            t32_r <= 1'b0;
            ts_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            sec_r <= sec_nxt;
            t32_r <= t32_nxt;
            ts_r <= ts_nxt;
        end
    end

    assign tick32_out = t32_r;
    assign tick_sec_out = ts_r;

endmodule

// >>> rtl/hprw_top.sv
`timescale 1ns/100ps
`include "hprw_params.svh"

// Behaviour
// - blank display and backlight while blanking enabled and host sense low
// - mask bit0 auto polarity, bit1 reset drives high, bit2 power drives high
// - auto polarity overrides both invert bits
// - mask bit5 key reboot, bit6 key wake, bit7 key shutdown
// - second byte sets power pulse length in 1/32 s ticks
// - one-byte config keeps the held pulse length
// - pulse length defaults to 32 ticks
// - length 255 drives power until host sense changes
// - config command answered with type 0x5C, no data
// - watchdog 0x1D one timeout byte, zero disables it
// - watchdog expiry pulses host reset like key reboot
// - watchdog off after reset, fires once until re-enabled
// - status shows function mask and watchdog counter
// - confirm held 4 s with sense high pulses reset 1 s, then self reset
// - confirm held 0.25 s with sense low pulses power for set length
// - cancel held 4 s with sense high pulses power, holding extends 5 s
// - reset and power pins float except during their pulse
module hprw_top
#(
    parameter int TICK_CYC = `HPRW_TICK_CYC
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_type_in,
    input wire logic [7:0] cmd_len_in,
    input wire logic [7:0] cmd_data0_in,
    input wire logic [7:0] cmd_data1_in,
    input wire logic host_sense_in,
    input wire logic key_confirm_in,
    input wire logic key_cancel_in,
    input wire logic rst_pin_in,
    input wire logic pwr_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_out,
    output logic pwr_pin_out,
    output logic pwr_pin_oe_out,
    output logic display_blank_out,
    output logic backlight_off_out,
    output logic rsp_valid_out,
    output logic [7:0] rsp_type_out,
    output logic [7:0] mask_out,
    output logic [7:0] wdog_count_out,
    output logic [7:0] pulse_len_out,
    output logic self_reset_out
);

    hprw_pkg::hprw_state_e state_r;
    hprw_pkg::hprw_state_e state_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] plen_r;
    logic [7:0] plen_nxt;
    logic [7:0] wd_r;
    logic [7:0] wd_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic sense_start_r;
    logic sense_start_nxt;
    logic self_after_r;
    logic self_after_nxt;
    logic extend_ok_r;
    logic extend_ok_nxt;
    logic [7:0] hold_c_r;
    logic [7:0] hold_c_nxt;
    logic [7:0] hold_x_r;
    logic [7:0] hold_x_nxt;
    logic lock_r;
    logic lock_nxt;
    logic rst_o_r;
    logic rst_o_nxt;
    logic rst_oe_r;
    logic rst_oe_nxt;
    logic pwr_o_r;
    logic pwr_o_nxt;
    logic pwr_oe_r;
    logic pwr_oe_nxt;
    logic blank_r;
    logic blank_nxt;
    logic rsp_v_r;
    logic rsp_v_nxt;
    logic [7:0] rsp_t_r;
    logic [7:0] rsp_t_nxt;
    logic self_r;
    logic self_nxt;
    logic tick32;
    logic tick_sec;
    logic tick_clr;
    logic pulse_done;
    logic idle;

    // active level of a pin: opposite of idle level, or the invert bit
    function automatic logic active_level(input logic auto_pol, input logic inv,
                                          input logic idle_lvl);
        active_level = auto_pol ? ~idle_lvl : inv;
    endfunction

    hprw_tick_gen #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clr_in(tick_clr),
        .tick32_out(tick32),
        .tick_sec_out(tick_sec)
    );

    assign idle = (state_r == hprw_pkg::HPRW_IDLE);
    // timed power pulse ends on the tick that reaches the length
    assign pulse_done = ({1'b0, cnt_r} + 9'h001) >= {1'b0, plen_r};

    // commands, watchdog and status
    always_comb
    begin
        mask_nxt = mask_r;
        plen_nxt = plen_r;
        wd_nxt = wd_r;
        pend_nxt = pend_r;
        rsp_v_nxt = 1'b0;
        rsp_t_nxt = rsp_t_r;
        tick_clr = 1'b0;
        blank_nxt = mask_r[`HPRW_BIT_BLANK] & ~host_sense_in;
        // service clears the pending expiry; a new expiry below wins
        if (idle && pend_r)
        begin
            pend_nxt = 1'b0;
        end
        if (cmd_valid_in && (cmd_type_in == `HPRW_CMD_PWR_CFG) &&
            ((cmd_len_in == `HPRW_LEN_ONE) || (cmd_len_in == `HPRW_LEN_TWO)))
        begin
            mask_nxt = cmd_data0_in;
            if (cmd_len_in == `HPRW_LEN_TWO)
            begin
                plen_nxt = cmd_data1_in;
            end
            rsp_v_nxt = 1'b1;
            rsp_t_nxt = `HPRW_RSP_OR | `HPRW_CMD_PWR_CFG;
        end
        else if (cmd_valid_in && (cmd_type_in == `HPRW_CMD_WDOG) &&
                 (cmd_len_in == `HPRW_LEN_ONE))
        begin
            wd_nxt = cmd_data0_in;
            tick_clr = 1'b1;
            rsp_v_nxt = 1'b1;
            rsp_t_nxt = `HPRW_RSP_OR | `HPRW_CMD_WDOG;
        end
        else if (tick_sec && (wd_r != 8'h00))
        begin
            wd_nxt = wd_r - 8'h01;
            if (wd_r == 8'h01)
            begin
                pend_nxt = 1'b1;
            end
        end
    end

    // key hold counters, locked while busy and until both keys are released
    always_comb
    begin
        lock_nxt = !idle || (lock_r && (key_confirm_in || key_cancel_in));
        hold_c_nxt = hold_c_r;
        hold_x_nxt = hold_x_r;
        if (!key_confirm_in || lock_r || !idle)
        begin
            hold_c_nxt = 8'h00;
        end
        else if (tick32 && (hold_c_r != 8'hFF))
        begin
            hold_c_nxt = hold_c_r + 8'h01;
        end
        if (!key_cancel_in || lock_r || !idle)
        begin
            hold_x_nxt = 8'h00;
        end
        else if (tick32 && (hold_x_r != 8'hFF))
        begin
            hold_x_nxt = hold_x_r + 8'h01;
        end
    end

    // pulse sequencer
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sense_start_nxt = sense_start_r;
        self_after_nxt = self_after_r;
        extend_ok_nxt = extend_ok_r;
        rst_o_nxt = rst_o_r;
        rst_oe_nxt = rst_oe_r;
        pwr_o_nxt = pwr_o_r;
        pwr_oe_nxt = pwr_oe_r;
        self_nxt = 1'b0;
        unique case (state_r)
            hprw_pkg::HPRW_IDLE:
            begin
                cnt_nxt = 8'h00;
                sense_start_nxt = host_sense_in;
                if (pend_r ||
                    (host_sense_in && mask_r[`HPRW_BIT_REBOOT] &&
                     (hold_c_r >= `HPRW_HOLD_LONG_TICKS)))
                begin
                    self_after_nxt = !pend_r;
                    rst_o_nxt = active_level(mask_r[`HPRW_BIT_AUTO_POL],
                                             mask_r[`HPRW_BIT_RST_INV], rst_pin_in);
                    rst_oe_nxt = 1'b1;
                    state_nxt = hprw_pkg::HPRW_RST_PULSE;
                end
                else if ((!host_sense_in && mask_r[`HPRW_BIT_WAKE] &&
                          (hold_c_r >= `HPRW_HOLD_SHORT_TICKS)) ||
                         (host_sense_in && mask_r[`HPRW_BIT_SHUTDOWN] &&
                          (hold_x_r >= `HPRW_HOLD_LONG_TICKS)))
                begin
                    self_after_nxt = !host_sense_in;
                    extend_ok_nxt = host_sense_in;
                    pwr_o_nxt = active_level(mask_r[`HPRW_BIT_AUTO_POL],
                                             mask_r[`HPRW_BIT_PWR_INV], pwr_pin_in);
                    pwr_oe_nxt = 1'b1;
                    state_nxt = hprw_pkg::HPRW_PWR_PULSE;
                end
            end
            hprw_pkg::HPRW_RST_PULSE:
            begin
                if (tick32)
                begin
                    if (cnt_r == (`HPRW_RST_PULSE_TICKS - 8'h01))
                    begin
                        rst_oe_nxt = 1'b0;
                        state_nxt = self_after_r ? hprw_pkg::HPRW_SELF_RST
                                                 : hprw_pkg::HPRW_IDLE;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 8'h01;
                    end
                end
            end
            hprw_pkg::HPRW_PWR_PULSE:
            begin
                if ((plen_r == `HPRW_PLEN_HOLD) ? (host_sense_in != sense_start_r)
                                                : (tick32 && pulse_done))
                begin
                    cnt_nxt = 8'h00;
                    if (extend_ok_r && key_cancel_in)
                    begin
                        state_nxt = hprw_pkg::HPRW_PWR_EXTEND;
                    end
                    else
                    begin
                        pwr_oe_nxt = 1'b0;
                        state_nxt = self_after_r ? hprw_pkg::HPRW_SELF_RST
                                                 : hprw_pkg::HPRW_IDLE;
                    end
                end
                else if (tick32)
                begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            hprw_pkg::HPRW_PWR_EXTEND:
            begin
                if (!key_cancel_in ||
                    (tick32 && (cnt_r == (`HPRW_EXTEND_TICKS - 8'h01))))
                begin
                    pwr_oe_nxt = 1'b0;
                    state_nxt = hprw_pkg::HPRW_IDLE;
                end
                else if (tick32)
                begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            hprw_pkg::HPRW_SELF_RST:
            begin
                self_nxt = 1'b1;
                state_nxt = hprw_pkg::HPRW_IDLE;
            end
            default:
            begin
                rst_oe_nxt = 1'b0;
                pwr_oe_nxt = 1'b0;
                state_nxt = hprw_pkg::HPRW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= hprw_pkg::HPRW_IDLE;
            mask_r <= `HPRW_MASK_RST;
            plen_r <= `HPRW_PLEN_RST;
            wd_r <= `HPRW_WDOG_RST;
            pend_r <= 1'b0;
            cnt_r <= 8'h00;
            sense_start_r <= 1'b0;
            self_after_r <= 1'b0;
            extend_ok_r <= 1'b0;
            hold_c_r <= 8'h00;
            hold_x_r <= 8'h00;
            lock_r <= 1'b0;
            rst_o_r <= 1'b0;
            rst_oe_r <= 1'b0;
            pwr_o_r <= 1'b0;
            pwr_oe_r <= 1'b0;
            blank_r <= 1'b0;
            rsp_v_r <= 1'b0;
            rsp_t_r <= 8'h00;
            self_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            mask_r <= mask_nxt;
            plen_r <= plen_nxt;
            wd_r <= wd_nxt;
            pend_r <= pend_nxt;
            cnt_r <= cnt_nxt;
            sense_start_r <= sense_start_nxt;
            self_after_r <= self_after_nxt;
            extend_ok_r <= extend_ok_nxt;
            hold_c_r <= hold_c_nxt;
            hold_x_r <= hold_x_nxt;
            lock_r <= lock_nxt;
            rst_o_r <= rst_o_nxt;
            rst_oe_r <= rst_oe_nxt;
            pwr_o_r <= pwr_o_nxt;
            pwr_oe_r <= pwr_oe_nxt;
            blank_r <= blank_nxt;
            rsp_v_r <= rsp_v_nxt;
            rsp_t_r <= rsp_t_nxt;
            self_r <= self_nxt;
        end
    end

    assign rst_pin_out = rst_o_r;
    assign rst_pin_oe_out = rst_oe_r;
    assign pwr_pin_out = pwr_o_r;
    assign pwr_pin_oe_out = pwr_oe_r;
    assign display_blank_out = blank_r;
    assign backlight_off_out = blank_r;
    assign rsp_valid_out = rsp_v_r;
    assign rsp_type_out = rsp_t_r;
    assign mask_out = mask_r;
    assign wdog_count_out = wd_r;
    assign pulse_len_out = plen_r;
    assign self_reset_out = self_r;

endmodule

// >>> tb/hprw_top_assertions.sv
`timescale 1ns/100ps
module hprw_top_assertions
#(
    parameter int TICK_CYC = 4
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_type_in,
    input wire logic [7:0] cmd_len_in,
    input wire logic [7:0] cmd_data0_in,
    input wire logic [7:0] cmd_data1_in,
    input wire logic host_sense_in,
    input wire logic rst_pin_in,
    input wire logic pwr_pin_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_out,
    input wire logic pwr_pin_out,
    input wire logic pwr_pin_oe_out,
    input wire logic display_blank_out,
    input wire logic backlight_off_out,
    input wire logic rsp_valid_out,
    input wire logic [7:0] rsp_type_out,
    input wire logic [7:0] mask_out,
    input wire logic [7:0] wdog_count_out,
    input wire logic [7:0] pulse_len_out
);
    localparam int LO = 31 * TICK_CYC - 1;
    localparam int HI = 32 * TICK_CYC + 2;
    logic [15:0] rst_cnt_r;
    logic [15:0] rst_cnt_nxt;
    wire cfg_ok = cmd_valid_in && cmd_type_in == 8'h1C && cmd_len_in inside {8'h01, 8'h02};
    wire wd_ok = cmd_valid_in && cmd_type_in == 8'h1D && cmd_len_in == 8'h01;
    // cycles the reset line has been driven
    always_comb rst_cnt_nxt = rst_pin_oe_out ? rst_cnt_r + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_cnt_r <= 16'h0000;
        else
            rst_cnt_r <= rst_cnt_nxt;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_cfg_rsp; cfg_ok |=> rsp_valid_out && rsp_type_out == 8'h5C; endproperty
    a_cfg_rsp: assert property (p_cfg_rsp) else $error("config reply wrong");
    property p_wd_rsp;
        wd_ok |=> rsp_valid_out && rsp_type_out == 8'h5D && wdog_count_out == $past(cmd_data0_in);
    endproperty
    a_wd_rsp: assert property (p_wd_rsp) else $error("watchdog reply wrong");
    property p_refuse; !cfg_ok && !wd_ok |=> !rsp_valid_out; endproperty
    a_refuse: assert property (p_refuse) else $error("reply without command");
    property p_keep_len;
        cfg_ok && cmd_len_in == 8'h01 |=> pulse_len_out == $past(pulse_len_out)
            && mask_out == $past(cmd_data0_in);
    endproperty
    a_keep_len: assert property (p_keep_len) else $error("short config");
    property p_set_len; cfg_ok && cmd_len_in == 8'h02 |=> pulse_len_out == $past(cmd_data1_in);
    endproperty
    a_set_len: assert property (p_set_len) else $error("pulse length");
    property p_blank;
        display_blank_out == ($past(mask_out[4]) && !$past(host_sense_in))
            && backlight_off_out == display_blank_out;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking wrong");
    property p_wd_step;
        !$past(wd_ok) && wdog_count_out != $past(wdog_count_out)
            |-> wdog_count_out == $past(wdog_count_out) - 8'h01;
    endproperty
    a_wd_step: assert property (p_wd_step) else $error("watchdog step");
    property p_fire;
        $past(wdog_count_out) == 8'h01 && wdog_count_out == 8'h00 && !$past(wd_ok)
            && !rst_pin_oe_out && !pwr_pin_oe_out |-> ##[1:4] rst_pin_oe_out;
    endproperty
    a_fire: assert property (p_fire) else $error("watchdog did not fire");
    property p_rst_pol;
        $rose(rst_pin_oe_out) |-> rst_pin_out ==
            ($past(mask_out[0]) ? !$past(rst_pin_in) : $past(mask_out[1]));
    endproperty
    a_rst_pol: assert property (p_rst_pol) else $error("reset level");
    property p_pwr_pol;
        $rose(pwr_pin_oe_out) |-> pwr_pin_out ==
            ($past(mask_out[0]) ? !$past(pwr_pin_in) : $past(mask_out[2]));
    endproperty
    a_pwr_pol: assert property (p_pwr_pol) else $error("power level");
    property p_steady; rst_pin_oe_out && $past(rst_pin_oe_out) |-> $stable(rst_pin_out);
    endproperty
    a_steady: assert property (p_steady) else $error("reset level moved");
    property p_rst_len; $fell(rst_pin_oe_out) |-> rst_cnt_r >= LO && rst_cnt_r <= HI;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
    c_cfg: cover property (cfg_ok);
    c_rst: cover property ($rose(rst_pin_oe_out));
    c_pwr: cover property ($rose(pwr_pin_oe_out));
endmodule
bind hprw_top hprw_top_assertions #(.TICK_CYC(TICK_CYC)) i_hprw_top_assertions (.*);

// >>> tb/hprw_host_model.sv
`timescale 1ns/100ps
module hprw_host_model
(
    input wire logic rst_drv_in,
    input wire logic rst_oe_in,
    input wire logic pwr_drv_in,
    input wire logic pwr_oe_in,
    input wire logic rst_pull_in,
    input wire logic pwr_pull_in,
    output logic rst_line_out,
    output logic pwr_line_out
);
    // released lines settle to the host's pull level
    assign rst_line_out = rst_oe_in ? rst_drv_in : rst_pull_in;
    assign pwr_line_out = pwr_oe_in ? pwr_drv_in : pwr_pull_in;
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int TC = 4;
    logic clk_sys_in = 0;
    logic rst_n_in = 0;
    logic cmd_valid_in = 0;
    logic [7:0] cmd_type_in = 8'h00;
    logic [7:0] cmd_len_in = 8'h00;
    logic [7:0] cmd_data0_in = 8'h00;
    logic [7:0] cmd_data1_in = 8'h00;
    logic host_sense_in = 0;
    logic key_confirm_in = 0;
    logic key_cancel_in = 0;
    logic rst_pull = 1;
    logic pwr_pull = 1;
    logic rst_pin_in, pwr_pin_in, rst_pin_out, rst_pin_oe_out, pwr_pin_out, pwr_pin_oe_out;
    logic display_blank_out, backlight_off_out, rsp_valid_out, self_reset_out;
    logic [7:0] rsp_type_out, mask_out, wdog_count_out, pulse_len_out, m, l;
    logic lvl;
    int n, seed = 88758, cyc = 0, n_errors = 0, tests_run = 0;
    logic [7:0] pol[5] = '{8'h00, 8'h04, 8'h01, 8'h05, 8'h07};
    logic [7:0] rpol[3] = '{8'h00, 8'h02, 8'h03};
    hprw_top #(.TICK_CYC(TC)) i_hprw_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .cmd_valid_in(cmd_valid_in), .cmd_type_in(cmd_type_in), .cmd_len_in(cmd_len_in),
        .cmd_data0_in(cmd_data0_in), .cmd_data1_in(cmd_data1_in), .host_sense_in(host_sense_in),
        .key_confirm_in(key_confirm_in), .key_cancel_in(key_cancel_in), .rst_pin_in(rst_pin_in),
        .pwr_pin_in(pwr_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
        .pwr_pin_out(pwr_pin_out), .pwr_pin_oe_out(pwr_pin_oe_out),
        .display_blank_out(display_blank_out), .backlight_off_out(backlight_off_out),
        .rsp_valid_out(rsp_valid_out), .rsp_type_out(rsp_type_out), .mask_out(mask_out),
        .wdog_count_out(wdog_count_out), .pulse_len_out(pulse_len_out),
        .self_reset_out(self_reset_out));
    hprw_host_model i_hprw_host_model (.rst_drv_in(rst_pin_out), .rst_oe_in(rst_pin_oe_out),
        .pwr_drv_in(pwr_pin_out), .pwr_oe_in(pwr_pin_oe_out), .rst_pull_in(rst_pull),
        .pwr_pull_in(pwr_pull), .rst_line_out(rst_pin_in), .pwr_line_out(pwr_pin_in));
    initial forever #10 clk_sys_in = ~clk_sys_in;
    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc >= 20000)
        begin
            n_errors++;
            summarize();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] t, input logic [7:0] len, d0, d1);
        @(negedge clk_sys_in);
        cmd_valid_in = 1;
        cmd_type_in = t;
        cmd_len_in = len;
        cmd_data0_in = d0;
        cmd_data1_in = d1;
        @(negedge clk_sys_in);
        cmd_valid_in = 0;
    endtask
    task automatic wait_pulse(input bit pwr, output logic lv, output int len);
        int k;
        k = 0;
        len = 0;
        while ((pwr ? pwr_pin_oe_out : rst_pin_oe_out) !== 1'b1 && k < 2000)
        begin
            @(negedge clk_sys_in);
            k++;
        end
        lv = pwr ? pwr_pin_out : rst_pin_out;
        while ((pwr ? pwr_pin_oe_out : rst_pin_oe_out) === 1'b1 && len < 3000)
        begin
            @(negedge clk_sys_in);
            len++;
        end
    endtask
    function automatic logic exp_lvl(input logic [7:0] mk, input logic idle, input int b);
        return mk[0] ? ~idle : mk[b];
    endfunction
    initial
    begin
        repeat (3) @(negedge clk_sys_in);
        rst_n_in = 1;
        check(mask_out, 8'h00);
        check(pulse_len_out, 8'h20);
        check(wdog_count_out, 8'h00);
        check({6'h00, rst_pin_oe_out, pwr_pin_oe_out}, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            m = 8'($random(seed)) & 8'h1F;
            l = 8'($random(seed));
            host_sense_in = 1'($random(seed));
            send(8'h1C, 8'h02, m, l);
            check({rsp_valid_out, rsp_type_out[6:0]}, 8'hDC);
            check(pulse_len_out, l);
            send(8'h1C, 8'h01, m ^ 8'h10, ~l);
            check(pulse_len_out, l);
            check(mask_out, m ^ 8'h10);
        end
        send(8'h1C, 8'h03, 8'h00, 8'h00);
        check({7'h00, rsp_valid_out}, 8'h00);
        send(8'h1C, 8'h01, 8'h10, 8'h00);
        host_sense_in = 0;
        repeat (2) @(negedge clk_sys_in);
        check({display_blank_out, backlight_off_out}, 2'b11);
        host_sense_in = 1;
        repeat (2) @(negedge clk_sys_in);
        check({display_blank_out, backlight_off_out}, 2'b00);
        host_sense_in = 0;
        for (int i = 0; i < 5; i++)
        begin
            m = 8'h40 | pol[i];
            l = 8'h02 + 8'(i);
            pwr_pull = i[0];
            send(8'h1C, 8'h02, m, l);
            key_confirm_in = 1;
            wait_pulse(1, lvl, n);
            key_confirm_in = 0;
            check(lvl, exp_lvl(m, pwr_pull, 2));
            check(n >= (l - 1) * TC && n <= l * TC + 1, 1);
            @(negedge clk_sys_in);
            check(self_reset_out, 1);
            repeat (8) @(negedge clk_sys_in);
        end
        send(8'h1C, 8'h02, 8'h40, 8'hFF);
        key_confirm_in = 1;
        wait_pulse(1, lvl, n);
        check(n, 3000);
        key_confirm_in = 0;
        repeat (1100) @(negedge clk_sys_in);
        check(pwr_pin_oe_out, 1);
        host_sense_in = 1;
        repeat (4) @(negedge clk_sys_in);
        check(pwr_pin_oe_out, 0);
        for (int i = 0; i < 3; i++)
        begin
            rst_pull = i[0];
            send(8'h1C, 8'h01, rpol[i], 8'h00);
            send(8'h1D, 8'h01, 8'h01, 8'h00);
            check({rsp_valid_out, rsp_type_out[6:0], wdog_count_out}, 16'hDD01);
            wait_pulse(0, lvl, n);
            check(lvl, exp_lvl(rpol[i], rst_pull, 1));
            check(n >= 31 * TC && n <= 32 * TC + 1, 1);
            @(negedge clk_sys_in);
            check(self_reset_out, 0);
            repeat (300) @(negedge clk_sys_in);
            check({wdog_count_out, rst_pin_oe_out}, 9'h000);
        end
        send(8'h1C, 8'h01, 8'h22, 8'h00);
        key_confirm_in = 1;
        repeat (400) @(negedge clk_sys_in);
        check(rst_pin_oe_out, 0);
        wait_pulse(0, lvl, n);
        key_confirm_in = 0;
        check(lvl, exp_lvl(8'h22, rst_pull, 1));
        check(n >= 31 * TC && n <= 32 * TC + 1, 1);
        @(negedge clk_sys_in);
        check(self_reset_out, 1);
        send(8'h1C, 8'h02, 8'h80, 8'h04);
        key_cancel_in = 1;
        wait_pulse(1, lvl, n);
        key_cancel_in = 0;
        check(lvl, exp_lvl(8'h80, pwr_pull, 2));
        check(n >= 163 * TC && n <= 164 * TC + 1, 1);
        @(negedge clk_sys_in);
        check(self_reset_out, 0);
        send(8'h1D, 8'h01, 8'h02, 8'h00);
        repeat (200) @(negedge clk_sys_in);
        send(8'h1D, 8'h01, 8'h02, 8'h00);
        repeat (200) @(negedge clk_sys_in);
        check({wdog_count_out, rst_pin_oe_out}, 9'h002);
        send(8'h1D, 8'h01, 8'h00, 8'h00);
        check(wdog_count_out, 8'h00);
        repeat (100) @(negedge clk_sys_in);
        check({wdog_count_out, rst_pin_oe_out}, 9'h000);
        rst_n_in = 0;
        repeat (3) @(negedge clk_sys_in);
        rst_n_in = 1;
        check(mask_out, 8'h00);
        check(pulse_len_out, 8'h20);
        summarize();
    end
endmodule
